// ---- common/ebac_defines.vh ----
// register map, field positions, reset values and timing counts of the nonvolatile byte controller
`ifndef EBAC_DEFINES_VH
`define EBAC_DEFINES_VH
// avalon byte offsets, one aligned word per register
`define EBAC_OFS_ADDR 5'h00
`define EBAC_OFS_DATA 5'h04
`define EBAC_OFS_BANK 5'h08
`define EBAC_OFS_PTR 5'h0C
`define EBAC_OFS_PORT 5'h10
`define EBAC_OFS_IRQ 5'h14
// where the control register sits behind the indirect port
`define EBAC_CTRL_BANK 1'h1
`define EBAC_CTRL_PTR 8'h40
// control register fields
`define EBAC_CTRL_PERMIT 3
`define EBAC_CTRL_WSTART 2
`define EBAC_CTRL_READ_ENABLE 1
`define EBAC_CTRL_RSTART 0
// interrupt register fields
`define EBAC_IRQ_EN 0
`define EBAC_IRQ_GIE 1
`define EBAC_IRQ_FLAG 2
// array geometry
`define EBAC_AW 6
`define EBAC_DEPTH 64
// reset values
`define EBAC_RST_BIT 1'h0
`define EBAC_RST_ADDR 6'h00
`define EBAC_RST_BYTE 8'h00
`define EBAC_RST_WORD 32'h00000000
`define EBAC_RST_CNT 4'h0
`define EBAC_RST_TCNT 8'h00
`define EBAC_ZERO24 24'h000000
`define EBAC_ZERO4 4'h0
`define EBAC_ZERO7 7'h00
// read cycle length: time in ns, cycles at 125 MHz rounded up
`define EBAC_CLK_NS 8
`define EBAC_READ_TIME_NS 40
`define EBAC_READ_CYCLES ((`EBAC_READ_TIME_NS + `EBAC_CLK_NS - 1) / `EBAC_CLK_NS)
// write cycle length in periods of the asynchronous write timer
`define EBAC_WRITE_TICKS 8'h04
`define EBAC_SYNC_STAGES 2
`endif

// ---- hdl/ebac_array.v ----
// 64 x 8 nonvolatile data array with one write port and a registered read port
`timescale 1ns/1ps
`include "ebac_defines.vh"
module ebac_array
(
  input wire i_clk,
  input wire i_we,
  input wire i_re,
  input wire [`EBAC_AW-1:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata
);
  reg [7:0] mem [0:`EBAC_DEPTH-1];

  // contents are kept across reset, as the cells are nonvolatile
  always @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_addr] <= i_wdata;
    end
    if (i_re)
    begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule

// ---- hdl/ebac_write_timer.v ----
// self-timed write cycle: counts periods of an oscillator that is asynchronous to i_clk
`timescale 1ns/1ps
`include "ebac_defines.vh"
module ebac_write_timer
(
  input wire i_clk,
  input wire i_reset,
  input wire i_osc,
  input wire i_start,
  output reg o_done
);
  reg [`EBAC_SYNC_STAGES-1:0] sync_reg;
  reg last_reg;
  reg run_reg;
  reg [7:0] tick_cnt_reg;
  wire tick;
  genvar g;

  // first stage feeds only the second; nothing else looks at it
  always @(posedge i_clk)
  begin
    sync_reg[0] <= i_osc;
  end
  generate
    for (g = 1; g < `EBAC_SYNC_STAGES; g = g + 1)
    begin : g_sync
      always @(posedge i_clk)
      begin
        sync_reg[g] <= sync_reg[g-1];
      end
    end
  endgenerate

  assign tick = sync_reg[`EBAC_SYNC_STAGES-1] & ~last_reg;

  // completion lands on whatever system edge follows the last tick, so its latency is not fixed
  always @(posedge i_clk)
  begin
    last_reg <= sync_reg[`EBAC_SYNC_STAGES-1];
    o_done <= 1'b0;
    if (i_reset)
    begin
      run_reg <= `EBAC_RST_BIT;
      tick_cnt_reg <= `EBAC_RST_TCNT;
      o_done <= `EBAC_RST_BIT;
    end
    else if (i_start)
    begin
      run_reg <= 1'b1;
      tick_cnt_reg <= `EBAC_RST_TCNT;
    end
    else if (run_reg && tick)
    begin
      if (tick_cnt_reg == `EBAC_WRITE_TICKS - 8'h01)
      begin
        run_reg <= 1'b0;
        o_done <= 1'b1;
      end
      else
      begin
        tick_cnt_reg <= tick_cnt_reg + 8'h01;
      end
    end
  end
endmodule

// ---- hdl/ebac_eeprom_ctrl.v ----
// nonvolatile byte access controller with avalon-mm register slave
// Summary of operation
// - read start runs read, self-clears when done
// - read start ignored unless read enable set
// - fetched byte held in data register
// - write start ignored while permit is low
// - write cycle timed by asynchronous timer
// - write start self-clears when write ends
// - permit cleared at power-on
// - bank select resets to zero
// - write end sets flag regardless of enable
// - vector only with both enables, stack free
// - flag clears when interrupt is serviced
// - array holds 64 bytes, 6-bit address
// - address register bits 5..0 only
// - control bits 3..0 as documented, cleared
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ebac_defines.vh"
module ebac_eeprom_ctrl
(
  input wire i_clk,
  input wire i_reset,
  input wire [4:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output wire [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  input wire i_write_osc,
  input wire i_stack_full,
  input wire i_irq_ack,
  output wire o_nvm_irq_req,
  output wire o_busy
);
  localparam ST_IDLE = 3'b001;
  localparam ST_READ = 3'b010;
  localparam ST_WRITE = 3'b100;
  // last count of the read cycle, cut to the counter width on purpose
  localparam [31:0] RD_LAST = `EBAC_READ_CYCLES - 1;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg ack_reg;
  reg [31:0] rdata_reg;
  reg [`EBAC_AW-1:0] nvm_addr_reg;
  reg [7:0] nvm_data_reg;
  reg bank_select_reg;
  reg [7:0] indirect_pointer_one_reg;
  reg program_permit_reg;
  reg wstart_reg;
  reg read_enable_reg;
  reg rstart_reg;
  reg nvm_irq_enable_reg;
  reg global_irq_enable_reg;
  reg nvm_irq_flag_reg;
  reg irq_req_reg;
  reg [`EBAC_AW-1:0] op_addr_reg;
  reg [7:0] op_data_reg;
  reg [3:0] rd_cnt_reg;
  reg [7:0] rd_mux;
  wire req;
  wire wr_take;
  wire [7:0] wd;
  wire ctrl_wr;
  wire start_rd;
  wire start_wr;
  wire rd_done;
  wire wr_done;
  wire [7:0] mem_q;
  wire [7:0] ctrl_val;

  // control register is visible only when bank and pointer both select it
  function ctrl_sel;
    input bank;
    input [7:0] ptr;
    begin
      ctrl_sel = (bank == `EBAC_CTRL_BANK) && (ptr == `EBAC_CTRL_PTR);
    end
  endfunction

  // bus handshake: one wait cycle, then the request is taken
  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_reg;
  assign o_avs_readdata = rdata_reg;
  assign wr_take = i_avs_write & ack_reg & i_avs_byteenable[0];
  assign wd = i_avs_writedata[7:0];
  assign ctrl_wr = wr_take && (i_avs_address == `EBAC_OFS_PORT) && ctrl_sel(bank_select_reg,
    indirect_pointer_one_reg);

  // enables are judged by their value before this write, so set-and-start in one write sets the enable but starts no cycle
  assign start_rd = ctrl_wr && wd[`EBAC_CTRL_RSTART] && !wd[`EBAC_CTRL_WSTART] && read_enable_reg
    && (state_reg == ST_IDLE);
  assign start_wr = ctrl_wr && wd[`EBAC_CTRL_WSTART] && !wd[`EBAC_CTRL_RSTART] && program_permit_reg
    && (state_reg == ST_IDLE);
  assign rd_done = (state_reg == ST_READ) && (rd_cnt_reg == RD_LAST[3:0]);

  assign ctrl_val = {`EBAC_ZERO4, program_permit_reg, wstart_reg, read_enable_reg, rstart_reg};
  assign o_busy = rstart_reg | wstart_reg;
  assign o_nvm_irq_req = irq_req_reg;

  ebac_array u_array
  (
    .i_clk(i_clk),
    .i_we(wr_done),
    .i_re(start_rd),
    .i_addr(start_rd ? nvm_addr_reg : op_addr_reg),
    .i_wdata(op_data_reg),
    .o_rdata(mem_q)
  );

  ebac_write_timer u_timer
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_osc(i_write_osc),
    .i_start(start_wr),
    .o_done(wr_done)
  );

  // readback selection; unimplemented bits and unmapped offsets read zero
  always @*
  begin
    rd_mux = `EBAC_RST_BYTE;
    case (i_avs_address)
      `EBAC_OFS_ADDR: rd_mux = {2'b00, nvm_addr_reg};
      `EBAC_OFS_DATA: rd_mux = nvm_data_reg;
      `EBAC_OFS_BANK: rd_mux = {`EBAC_ZERO7, bank_select_reg};
      `EBAC_OFS_PTR: rd_mux = indirect_pointer_one_reg;
      `EBAC_OFS_PORT: rd_mux = ctrl_sel(bank_select_reg, indirect_pointer_one_reg) ? ctrl_val
        : `EBAC_RST_BYTE;
      `EBAC_OFS_IRQ: rd_mux = {5'b00000, nvm_irq_flag_reg, global_irq_enable_reg, nvm_irq_enable_reg};
      default: rd_mux = `EBAC_RST_BYTE;
    endcase
  end

  // sequencer
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (start_rd)
        begin
          state_next = ST_READ;
        end
        else if (start_wr)
        begin
          state_next = ST_WRITE;
        end
      end
      ST_READ:
      begin
        if (rd_done)
        begin
          state_next = ST_IDLE;
        end
      end
      ST_WRITE:
      begin
        if (wr_done)
        begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // bus answer: data captured in the wait cycle and stands while waitrequest is low
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ack_reg <= `EBAC_RST_BIT;
      rdata_reg <= `EBAC_RST_WORD;
    end
    else
    begin
      ack_reg <= req & ~ack_reg;
      if (req && !ack_reg)
      begin
        rdata_reg <= {`EBAC_ZERO24, rd_mux};
      end
    end
  end

  // directly mapped registers and the operation snapshot
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_reg <= ST_IDLE;
      nvm_addr_reg <= `EBAC_RST_ADDR;
      nvm_data_reg <= `EBAC_RST_BYTE;
      bank_select_reg <= `EBAC_RST_BIT;
      indirect_pointer_one_reg <= `EBAC_RST_BYTE;
      op_addr_reg <= `EBAC_RST_ADDR;
      op_data_reg <= `EBAC_RST_BYTE;
      rd_cnt_reg <= `EBAC_RST_CNT;
    end
    else
    begin
      state_reg <= state_next;
      if (wr_take && i_avs_address == `EBAC_OFS_ADDR)
      begin
        nvm_addr_reg <= wd[`EBAC_AW-1:0];
      end
      if (wr_take && i_avs_address == `EBAC_OFS_BANK)
      begin
        bank_select_reg <= wd[0];
      end
      if (wr_take && i_avs_address == `EBAC_OFS_PTR)
      begin
        indirect_pointer_one_reg <= wd;
      end
      // a finished read owns the data register over a software store in the same edge
      if (rd_done)
      begin
        nvm_data_reg <= mem_q;
      end
      else if (wr_take && i_avs_address == `EBAC_OFS_DATA)
      begin
        nvm_data_reg <= wd;
      end
      if (start_rd || start_wr)
      begin
        op_addr_reg <= nvm_addr_reg;
        op_data_reg <= nvm_data_reg;
      end
      if (state_reg == ST_READ)
      begin
        rd_cnt_reg <= rd_cnt_reg + 4'h1;
      end
      else
      begin
        rd_cnt_reg <= `EBAC_RST_CNT;
      end
    end
  end

  // control register: start bits are hardware owned once set; software cannot cancel a cycle
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      program_permit_reg <= `EBAC_RST_BIT;
      wstart_reg <= `EBAC_RST_BIT;
      read_enable_reg <= `EBAC_RST_BIT;
      rstart_reg <= `EBAC_RST_BIT;
    end
    else
    begin
      if (ctrl_wr)
      begin
        program_permit_reg <= wd[`EBAC_CTRL_PERMIT];
        read_enable_reg <= wd[`EBAC_CTRL_READ_ENABLE];
      end
      if (start_rd)
      begin
        rstart_reg <= 1'b1;
      end
      else if (rd_done)
      begin
        rstart_reg <= 1'b0;
      end
      if (start_wr)
      begin
        wstart_reg <= 1'b1;
      end
      else if (wr_done)
      begin
        wstart_reg <= 1'b0;
      end
    end
  end

  // interrupt flag: write end sets it, service clears it; set wins a tie
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      nvm_irq_enable_reg <= `EBAC_RST_BIT;
      global_irq_enable_reg <= `EBAC_RST_BIT;
      nvm_irq_flag_reg <= `EBAC_RST_BIT;
      irq_req_reg <= `EBAC_RST_BIT;
    end
    else
    begin
      if (wr_take && i_avs_address == `EBAC_OFS_IRQ)
      begin
        nvm_irq_enable_reg <= wd[`EBAC_IRQ_EN];
        global_irq_enable_reg <= wd[`EBAC_IRQ_GIE];
      end
      if (wr_done)
      begin
        nvm_irq_flag_reg <= 1'b1;
      end
      else if (i_irq_ack)
      begin
        nvm_irq_flag_reg <= 1'b0;
      end
      irq_req_reg <= nvm_irq_flag_reg & ~(i_irq_ack & ~wr_done) & nvm_irq_enable_reg
        & global_irq_enable_reg & ~i_stack_full;
    end
  end
endmodule

// ---- tb/ebac_props.sv ----
// port-level assertions for the nonvolatile byte controller
`timescale 1ns/1ps
module ebac_props
(
  input wire i_clk,
  input wire i_reset,
  input wire [4:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire i_stack_full,
  input wire i_irq_ack,
  input wire o_nvm_irq_req,
  input wire o_busy
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // a fresh request, and the shortest life of any started cycle
  sequence req_first;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence busy_run;
    o_busy [*5];
  endsequence
  a_wait_one_cycle: assert property (req_first |=> !o_avs_waitrequest)
    else $error("waitrequest not low in second cycle");
  a_wait_idle_low: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
    else $error("waitrequest high while idle");
  a_read_high_zero: assert property (o_avs_readdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  a_busy_needs_start: assert property ($rose(o_busy) |->
    $past(i_avs_write && !o_avs_waitrequest && i_avs_address == 5'h10))
    else $error("cycle began without a taken port write");
  a_busy_min_len: assert property ($rose(o_busy) |-> busy_run)
    else $error("cycle shorter than five clocks");
  a_busy_bounded: assert property ($rose(o_busy) |-> ##[1:200] !o_busy)
    else $error("start bit never cleared");
  a_irq_stack_free: assert property (o_nvm_irq_req |-> $past(!i_stack_full))
    else $error("interrupt requested with stack full");
  a_ack_clears: assert property (i_irq_ack && !o_busy |=> !o_nvm_irq_req)
    else $error("request stayed after service");
endmodule

// ---- tb/ebac_core_model.sv ----
// core-side model: write timer oscillator, stack state and interrupt service
`timescale 1ns/1ps
module ebac_core_model
(
  input wire i_clk,
  input wire i_irq_req,
  input wire i_hold_full,
  output reg o_write_osc,
  output wire o_stack_full,
  output reg o_irq_ack
);
  // period unrelated to the 8 ns clock, so sync latency varies per cycle
  initial
  begin
    o_write_osc = 1'b0;
    forever #17.3 o_write_osc = ~o_write_osc;
  end
  assign o_stack_full = i_hold_full;
  // vector one cycle after the request; one-cycle acknowledge
  initial o_irq_ack = 1'b0;
  always @(posedge i_clk)
    o_irq_ack <= i_irq_req & ~o_irq_ack;
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the nonvolatile byte controller
`timescale 1ns/1ps
`include "ebac_defines.vh"
module testbench;
  reg i_clk;
  reg i_reset;
  reg [4:0] addr;
  reg rd_r;
  reg wr_r;
  reg [31:0] wdata;
  reg [3:0] be;
  reg hold_full;
  reg [7:0] ie;
  reg [31:0] v;
  wire [31:0] rdata;
  wire waitreq;
  wire osc;
  wire full;
  wire ack;
  wire irq;
  wire busy;
  integer fails;
  integer tests_run;
  integer cycles;
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  ebac_eeprom_ctrl dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_avs_address(addr), .i_avs_read(rd_r),
    .i_avs_write(wr_r), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_write_osc(osc), .i_stack_full(full), .i_irq_ack(ack),
    .o_nvm_irq_req(irq), .o_busy(busy));
  ebac_core_model core_u (.i_clk(i_clk), .i_irq_req(irq), .i_hold_full(hold_full), .o_write_osc(osc),
    .o_stack_full(full), .o_irq_ack(ack));
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  // a hung handshake ends the run as a mismatch
  always @(posedge i_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      fails = fails + 1;
      report_and_stop;
    end
  end
  task chk(input string n, input [31:0] e, input [31:0] g);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  // one bus cycle; the leading idle edge keeps a release and a new request apart
  task bus(input w, input [4:0] a, input [7:0] d);
  begin
    @(posedge i_clk);
    addr <= a;
    wr_r <= w;
    rd_r <= !w;
    wdata <= {24'h000000, d};
    @(posedge i_clk);
    while (waitreq)
      @(posedge i_clk);
    v = rdata;
    wr_r <= 1'b0;
    rd_r <= 1'b0;
  end
  endtask
  // poll the control register until the start bits in m drop, bounded
  task poll(input [7:0] m);
  begin
    bus(1'b0, `EBAC_OFS_PORT, 8'h00);
    repeat (60)
      if ((v[7:0] & m) != 8'h00)
        bus(1'b0, `EBAC_OFS_PORT, 8'h00);
  end
  endtask
  task t_reset;
  begin
    bus(1'b0, `EBAC_OFS_BANK, 8'h00);
    chk("bank", 32'h0, v);
    bus(1'b0, `EBAC_OFS_IRQ, 8'h00);
    chk("irq reg", 32'h0, v);
    bus(1'b0, 5'h18, 8'h00);
    chk("unmapped", 32'h0, v);
    bus(1'b1, `EBAC_OFS_PTR, `EBAC_CTRL_PTR);
    bus(1'b1, `EBAC_OFS_PORT, 8'h08);
    bus(1'b0, `EBAC_OFS_PORT, 8'h00);
    chk("port bank0", 32'h0, v);
    bus(1'b1, `EBAC_OFS_BANK, 8'h01);
    bus(1'b0, `EBAC_OFS_PORT, 8'h00);
    chk("ctrl", 32'h0, v);
    bus(1'b1, `EBAC_OFS_ADDR, 8'hFF);
    be <= 4'hE;
    bus(1'b1, `EBAC_OFS_ADDR, 8'h11);
    be <= 4'hF;
    bus(1'b0, `EBAC_OFS_ADDR, 8'h00);
    chk("addr", 32'h3F, v);
  end
  endtask
  // enable and start in one write: enable lands, start is ignored
  task t_refuse;
  begin
    bus(1'b1, `EBAC_OFS_PORT, 8'h0C);
    bus(1'b0, `EBAC_OFS_PORT, 8'h00);
    chk("ctrl", 32'h08, v);
    bus(1'b1, `EBAC_OFS_PORT, 8'h03);
    bus(1'b0, `EBAC_OFS_PORT, 8'h00);
    chk("ctrl", 32'h02, v);
    bus(1'b1, `EBAC_OFS_PORT, 8'h0A);
    bus(1'b1, `EBAC_OFS_PORT, 8'h0F);
    bus(1'b0, `EBAC_OFS_PORT, 8'h00);
    chk("ctrl both", 32'h0A, v);
    chk("busy both", 32'h0, busy);
    bus(1'b1, `EBAC_OFS_PORT, 8'h00);
  end
  endtask
  task t_write(input [7:0] a, input [7:0] d);
  begin
    bus(1'b1, `EBAC_OFS_ADDR, a);
    bus(1'b1, `EBAC_OFS_DATA, d);
    bus(1'b1, `EBAC_OFS_IRQ, ie & 8'h01);
    bus(1'b1, `EBAC_OFS_PORT, 8'h08);
    bus(1'b1, `EBAC_OFS_PORT, 8'h0C);
    bus(1'b1, `EBAC_OFS_IRQ, ie);
    poll(8'h04);
    chk("write end", 32'h08, v);
    chk("busy", 32'h0, busy);
    bus(1'b1, `EBAC_OFS_PORT, 8'h00);
  end
  endtask
  task t_read(input [7:0] a, input [7:0] e);
  begin
    bus(1'b1, `EBAC_OFS_PORT, 8'h02);
    bus(1'b1, `EBAC_OFS_ADDR, a);
    bus(1'b1, `EBAC_OFS_PORT, 8'h03);
    poll(8'h01);
    chk("read end", 32'h02, v);
    chk("busy", 32'h0, busy);
    bus(1'b0, `EBAC_OFS_DATA, 8'h00);
    chk("data", {24'h000000, e}, v);
    bus(1'b1, `EBAC_OFS_PORT, 8'h00);
    bus(1'b0, `EBAC_OFS_DATA, 8'h00);
    chk("data held", {24'h000000, e}, v);
  end
  endtask
  // flag set while masked, blocked by a full stack, then serviced
  task t_irq;
  begin
    bus(1'b0, `EBAC_OFS_IRQ, 8'h00);
    chk("flag", 32'h04, v);
    chk("req masked", 32'h0, irq);
    bus(1'b1, `EBAC_OFS_IRQ, 8'h01);
    bus(1'b0, `EBAC_OFS_IRQ, 8'h00);
    chk("flag", 32'h05, v);
    chk("req no gie", 32'h0, irq);
    hold_full <= 1'b1;
    ie = 8'h03;
    bus(1'b1, `EBAC_OFS_IRQ, ie);
    bus(1'b0, `EBAC_OFS_IRQ, 8'h00);
    chk("req full", 32'h0, irq);
    hold_full <= 1'b0;
    bus(1'b0, `EBAC_OFS_IRQ, 8'h00);
    bus(1'b0, `EBAC_OFS_IRQ, 8'h00);
    chk("flag serviced", 32'h03, v);
  end
  endtask
  // reset in mid-run: permit and bank drop, pointer clears, array keeps its bytes
  task t_rereset;
  begin
    bus(1'b1, `EBAC_OFS_PORT, 8'h08);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    bus(1'b0, `EBAC_OFS_BANK, 8'h00);
    chk("bank again", 32'h0, v);
    bus(1'b0, `EBAC_OFS_PTR, 8'h00);
    chk("pointer", 32'h0, v);
    bus(1'b1, `EBAC_OFS_BANK, 8'h01);
    bus(1'b1, `EBAC_OFS_PTR, `EBAC_CTRL_PTR);
    bus(1'b0, `EBAC_OFS_PORT, 8'h00);
    chk("ctrl again", 32'h0, v);
    chk("busy again", 32'h0, busy);
    t_read(8'h01, 8'hC3);
  end
  endtask
  initial
  begin
    i_reset = 1'b1;
    addr = 5'h00;
    rd_r = 1'b0;
    wr_r = 1'b0;
    wdata = 32'h00000000;
    be = 4'hF;
    hold_full = 1'b0;
    ie = 8'h00;
    fails = 0;
    tests_run = 0;
    cycles = 0;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset;
    t_refuse;
    t_write(8'h00, 8'hA5);
    t_write(8'h3F, 8'h5A);
    t_read(8'h00, 8'hA5);
    t_read(8'h3F, 8'h5A);
    t_irq;
    t_write(8'h01, 8'hC3);
    t_read(8'h01, 8'hC3);
    t_rereset;
    report_and_stop;
  end
endmodule
bind ebac_eeprom_ctrl ebac_props chk_u (.i_clk(i_clk), .i_reset(i_reset), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_stack_full(i_stack_full), .i_irq_ack(i_irq_ack),
  .o_nvm_irq_req(o_nvm_irq_req), .o_busy(o_busy));
